// File: float_status_pkg.sv
`default_nettype none
package float_status_pkg;
   // Register map on the AXI4-Lite bus.
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0000;
   localparam int ADDR_DECODE_BITS = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int STATUS_WIDTH = 16;

   // Field positions in the status register.
   localparam int FLOAT_ERROR_BIT = 15;
   localparam int GLOBAL_DISABLE_BIT = 14;
   localparam int RESERVED_HI_BIT = 13;
   localparam int RESERVED_LO_BIT = 12;
   localparam int UNDEF_ENABLE_BIT = 11;
   localparam int UNDERFLOW_ENABLE_BIT = 10;
   localparam int OVERFLOW_ENABLE_BIT = 9;
   localparam int CONVERSION_ENABLE_BIT = 8;
   localparam int DOUBLE_MODE_BIT = 7;
   localparam int LONG_MODE_BIT = 6;
   localparam int CHOP_MODE_BIT = 5;
   localparam int RESERVED_MID_BIT = 4;
   localparam int NEGATIVE_BIT = 3;
   localparam int ZERO_BIT = 2;
   localparam int EXP_OVERFLOW_BIT = 1;
   localparam int CARRY_BIT = 0;

   // Reset value and the bits that software may load.
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] STATUS_WRITE_MASK = 16'hcfef;

   // Operand word layout: sign bit and biased exponent field.
   localparam int OPERAND_SIGN_BIT = 15;
   localparam int OPERAND_EXP_HI = 14;
   localparam int OPERAND_EXP_LO = 7;

   // Integer widths for conversions.
   localparam int SHORT_INT_BITS = 16;
   localparam int LONG_INT_BITS = 32;
   localparam int CONV_VALUE_BITS = 64;

   // Operand presented by the datapath before an instruction executes.
   typedef struct packed {
      logic valid;
      logic from_memory;
      logic checked_opcode;
      logic [15:0] word;
   } operand_check_type;

   // Outcome reported by the datapath once an operation has computed.
   typedef struct packed {
      logic valid;
      logic sign;
      logic [9:0] exponent;
      logic overflow;
      logic underflow;
      logic divide_by_zero;
      logic illegal_opcode;
      logic conversion;
      logic from_double;
      logic carry_out;
      logic [63:0] conv_value;
   } result_report_type;

   // Store directions returned to the datapath.
   typedef struct packed {
      logic valid;
      logic force_zero;
      logic sign;
      logic [7:0] exponent;
   } store_control_type;
endpackage : float_status_pkg
`default_nettype wire

// File: int_range_check.sv
`timescale 1ns/1ns
`default_nettype none
module int_range_check (
   // Converted integer and selected width.
   input wire logic [63:0] conv_value,
   input wire logic long_integer_mode,
   // Conversion outcome.
   output logic conv_fail
);
   logic fits_short;
   logic fits_long;

   // A value fits when every bit above the sign bit repeats the sign.
   assign fits_short = (&conv_value[63:float_status_pkg::SHORT_INT_BITS - 1]) |
                       ~(|conv_value[63:float_status_pkg::SHORT_INT_BITS - 1]);
   assign fits_long = (&conv_value[63:float_status_pkg::LONG_INT_BITS - 1]) |
                      ~(|conv_value[63:float_status_pkg::LONG_INT_BITS - 1]);
   assign conv_fail = long_integer_mode ? ~fits_long : ~fits_short;
endmodule : int_range_check
`default_nettype wire

// File: float_status_mode_register.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Bits 13, 12 and 4 are reserved, hold nothing, read zero.
// - Bit 11 set traps on a negative-zero memory operand of listed instructions.
// - Only memory operands are checked; accumulator operands never trap.
// - A negative-zero result is stored only together with a trap.
// - Bit 10 set traps underflow; stored exponent keeps its low eight bits.
// - Bit 9 set traps overflow; stored exponent keeps its low eight bits.
// - Overflow with bit 9 clear stores exact zero and raises no trap.
// - Bit 8 set traps failed integer conversion; destination gets zero.
// - Failed conversion with bit 8 clear stores zero without a trap.
// - Conversion fails when the integer exceeds the selected width.
// - Bit 7 selects double precision when set, single when clear.
// - Bit 6 selects 32-bit integers when set, 16-bit when clear.
// - Bit 5 selects chopped results when set, rounded when clear.
// - Bit 3 shows a negative last result.
// - Bit 2 shows a zero last result.
// - Bit 1 shows exponent overflow in the last operation.
// - Bit 0 shows carry out, only in double-to-integer conversions.
// - Bit 15 stays set until software loads the register.
// - Bit 14 set suppresses FP_TRAP; OPERAND_TRAP still rises.
// - Bit 15 sets on divide by zero, illegal opcode or enabled exception.
module float_status_mode_register (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // AXI4-Lite write address and data.
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // AXI4-Lite write response.
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // AXI4-Lite read.
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [31:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // Datapath reports.
   input wire float_status_pkg::operand_check_type OPERAND_CHECK,
   input wire float_status_pkg::result_report_type RESULT_REPORT,
   // Answers to the datapath and trap logic.
   output logic OPERAND_DONE,
   output logic OPERAND_TRAP,
   output float_status_pkg::store_control_type STORE_CONTROL,
   output logic FP_TRAP,
   // Mode outputs.
   output logic DOUBLE_MODE,
   output logic LONG_MODE,
   output logic CHOP_MODE
);
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic aw_full_reg;
   logic w_full_reg;
   logic [31:0] aw_addr_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg;
   logic aw_ready_reg;
   logic w_ready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic operand_done_reg;
   logic operand_trap_reg;
   logic fp_trap_reg;
   float_status_pkg::store_control_type store_reg;
   float_status_pkg::store_control_type store_next;

   // Address decode shared by the read and write paths.
   function automatic logic is_status_addr(input logic [31:0] addr);
      is_status_addr = addr[float_status_pkg::ADDR_DECODE_BITS - 1:0] ==
                       float_status_pkg::STATUS_OFFSET[float_status_pkg::ADDR_DECODE_BITS - 1:0];
   endfunction : is_status_addr

   // Negative zero: sign set and biased exponent zero.
   function automatic logic is_neg_zero(input logic [15:0] word);
      is_neg_zero = word[float_status_pkg::OPERAND_SIGN_BIT] &
                    ~(|word[float_status_pkg::OPERAND_EXP_HI:float_status_pkg::OPERAND_EXP_LO]);
   endfunction : is_neg_zero

   // Global disable and trap enable bits as named wires.
   logic irq_off;
   logic undef_en;
   logic underflow_en;
   logic overflow_en;
   logic conversion_en;
   assign irq_off = status_reg[float_status_pkg::GLOBAL_DISABLE_BIT];
   assign undef_en = status_reg[float_status_pkg::UNDEF_ENABLE_BIT];
   assign underflow_en = status_reg[float_status_pkg::UNDERFLOW_ENABLE_BIT];
   assign overflow_en = status_reg[float_status_pkg::OVERFLOW_ENABLE_BIT];
   assign conversion_en = status_reg[float_status_pkg::CONVERSION_ENABLE_BIT];

   // Write channel handshakes and the commit of a complete write.
   logic aw_take;
   logic w_take;
   logic commit;
   logic sw_write;
   logic [15:0] sw_merged;
   logic aw_full_next;
   logic w_full_next;
   assign aw_take = AWVALID & aw_ready_reg;
   assign w_take = WVALID & w_ready_reg;
   assign commit = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign sw_write = commit & is_status_addr(aw_addr_reg);
   assign sw_merged = {w_strb_reg[1] ? w_data_reg[15:8] : status_reg[15:8],
                       w_strb_reg[0] ? w_data_reg[7:0] : status_reg[7:0]};
   assign aw_full_next = commit ? 1'b0 : (aw_full_reg | aw_take);
   assign w_full_next = commit ? 1'b0 : (w_full_reg | w_take);

   // Operand check before execution.
   logic undef_hit;
   assign undef_hit = OPERAND_CHECK.valid & OPERAND_CHECK.from_memory &
                      OPERAND_CHECK.checked_opcode & undef_en &
                      is_neg_zero(OPERAND_CHECK.word);

   // Conversion range check.
   logic conv_fail;
   int_range_check range_check (
      .conv_value(RESULT_REPORT.conv_value),
      .long_integer_mode(status_reg[float_status_pkg::LONG_MODE_BIT]),
      .conv_fail(conv_fail)
   );

   // Exception classification of a reported result.
   logic res_valid;
   logic conv_bad;
   logic ovf_exc;
   logic unf_exc;
   logic conv_exc;
   logic always_exc;
   logic result_error;
   logic result_trap;
   logic any_trap;
   logic set_error;
   assign res_valid = RESULT_REPORT.valid;
   assign conv_bad = res_valid & RESULT_REPORT.conversion & conv_fail;
   assign ovf_exc = res_valid & RESULT_REPORT.overflow & overflow_en;
   assign unf_exc = res_valid & RESULT_REPORT.underflow & underflow_en;
   assign conv_exc = conv_bad & conversion_en;
   assign always_exc = res_valid & (RESULT_REPORT.divide_by_zero | RESULT_REPORT.illegal_opcode);
   assign result_error = ovf_exc | unf_exc | conv_exc | always_exc;
   assign set_error = result_error | undef_hit;
   assign result_trap = result_error & ~irq_off;
   assign any_trap = set_error & ~irq_off;

   // Store directions for the result.
   logic [7:0] low_exp;
   logic lost_ovf;
   logic lost_unf;
   logic neg_zero_res;
   logic store_zero;
   assign low_exp = RESULT_REPORT.exponent[7:0];
   assign lost_ovf = RESULT_REPORT.overflow & ~overflow_en;
   assign lost_unf = RESULT_REPORT.underflow & ~underflow_en;
   assign neg_zero_res = RESULT_REPORT.sign & ~(|low_exp) & ~result_trap;
   assign store_zero = conv_bad | lost_ovf | lost_unf | neg_zero_res;

   // Next store control word.
   always_comb begin
      store_next.valid = res_valid;
      store_next.force_zero = res_valid & store_zero;
      store_next.sign = store_zero ? 1'b0 : RESULT_REPORT.sign;
      store_next.exponent = store_zero ? 8'h00 : low_exp;
   end

   // Next status value: software load first, hardware updates on top so a set wins.
   always_comb begin
      status_next = status_reg;
      if (sw_write) begin
         status_next = sw_merged & float_status_pkg::STATUS_WRITE_MASK;
      end
      if (res_valid & ~conv_bad) begin
         status_next[float_status_pkg::NEGATIVE_BIT] = ~store_zero & RESULT_REPORT.sign;
         status_next[float_status_pkg::ZERO_BIT] = store_zero | ~(|low_exp);
         status_next[float_status_pkg::EXP_OVERFLOW_BIT] = RESULT_REPORT.overflow;
         status_next[float_status_pkg::CARRY_BIT] = RESULT_REPORT.carry_out &
                                                    RESULT_REPORT.conversion &
                                                    RESULT_REPORT.from_double;
      end
      if (set_error) begin
         status_next[float_status_pkg::FLOAT_ERROR_BIT] = 1'b1;
      end
   end

   // Status register.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         status_reg <= float_status_pkg::STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end
   // Datapath answers, one cycle after the report.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         operand_done_reg <= 1'b0;
         operand_trap_reg <= 1'b0;
         fp_trap_reg <= 1'b0;
         store_reg <= '0;
      end else begin
         operand_done_reg <= OPERAND_CHECK.valid;
         operand_trap_reg <= undef_hit;
         fp_trap_reg <= any_trap;
         store_reg <= store_next;
      end
   end
   // Write address and data holding registers.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_ready_reg <= 1'b1;
         w_ready_reg <= 1'b1;
         aw_addr_reg <= 32'h0000_0000;
         w_data_reg <= 16'h0000;
         w_strb_reg <= 2'h0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_ready_reg <= ~aw_full_next;
         w_ready_reg <= ~w_full_next;
         if (aw_take) begin
            aw_addr_reg <= AWADDR;
         end
         if (w_take) begin
            w_data_reg <= WDATA[15:0];
            w_strb_reg <= WSTRB[1:0];
         end
      end
   end
   // Write response.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= float_status_pkg::RESP_OKAY;
      end else if (commit) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= is_status_addr(aw_addr_reg) ? float_status_pkg::RESP_OKAY :
                      float_status_pkg::RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_reg <= 1'b0;
      end
   end
   // Read channel: one read in flight, data registered at the address edge.
   logic ar_take;
   assign ar_take = ARVALID & arready_reg;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= float_status_pkg::RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= is_status_addr(ARADDR) ? {16'h0000, status_reg} : 32'h0000_0000;
         rresp_reg <= is_status_addr(ARADDR) ? float_status_pkg::RESP_OKAY :
                      float_status_pkg::RESP_SLVERR;
      end else if (rvalid_reg & RREADY) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end
   // Outputs straight from flip-flops.
   assign AWREADY = aw_ready_reg;
   assign WREADY = w_ready_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = arready_reg;
   assign RVALID = rvalid_reg;
   assign RDATA = rdata_reg;
   assign RRESP = rresp_reg;
   assign OPERAND_DONE = operand_done_reg;
   assign OPERAND_TRAP = operand_trap_reg;
   assign FP_TRAP = fp_trap_reg;
   assign STORE_CONTROL = store_reg;
   assign DOUBLE_MODE = status_reg[float_status_pkg::DOUBLE_MODE_BIT];
   assign LONG_MODE = status_reg[float_status_pkg::LONG_MODE_BIT];
   assign CHOP_MODE = status_reg[float_status_pkg::CHOP_MODE_BIT];
   // Checks on the block's own behaviour.
   a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
      !status_reg[float_status_pkg::RESERVED_HI_BIT] &&
      !status_reg[float_status_pkg::RESERVED_LO_BIT] &&
      !status_reg[float_status_pkg::RESERVED_MID_BIT])
      else $error("Reserved status bit is set.");
   a_undef_trap: assert property (@(posedge CORE_CLK) disable iff (RST)
      OPERAND_CHECK.valid && OPERAND_CHECK.from_memory && OPERAND_CHECK.checked_opcode &&
      undef_en && !irq_off && is_neg_zero(OPERAND_CHECK.word)
      |=> OPERAND_TRAP && FP_TRAP && OPERAND_DONE)
      else $error("Negative-zero memory operand did not trap.");
   a_accum_no_trap: assert property (@(posedge CORE_CLK) disable iff (RST)
      OPERAND_CHECK.valid && (!OPERAND_CHECK.from_memory || !undef_en) |=> !OPERAND_TRAP)
      else $error("Operand trap without a memory operand and enable.");
   a_neg_zero_store: assert property (@(posedge CORE_CLK) disable iff (RST)
      STORE_CONTROL.valid && STORE_CONTROL.sign && STORE_CONTROL.exponent == 8'h00 |-> FP_TRAP)
      else $error("Negative zero stored without a trap.");
   a_ovf_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
      RESULT_REPORT.valid && RESULT_REPORT.overflow && !overflow_en
      |=> STORE_CONTROL.force_zero && STORE_CONTROL.exponent == 8'h00)
      else $error("Disabled overflow did not store exact zero.");
   a_conv_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
      RESULT_REPORT.valid && RESULT_REPORT.conversion && conv_fail
      |=> STORE_CONTROL.force_zero && $stable(status_reg[3:0]))
      else $error("Failed conversion did not store zero.");
   a_error_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
      status_reg[float_status_pkg::FLOAT_ERROR_BIT] && !sw_write
      |=> status_reg[float_status_pkg::FLOAT_ERROR_BIT])
      else $error("Error flag cleared without a software load.");
   a_error_set: assert property (@(posedge CORE_CLK) disable iff (RST)
      RESULT_REPORT.valid && RESULT_REPORT.divide_by_zero
      |=> status_reg[float_status_pkg::FLOAT_ERROR_BIT])
      else $error("Divide by zero did not set the error flag.");
   a_disable_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
      FP_TRAP |-> !$past(irq_off))
      else $error("Trap raised while traps were disabled.");
   a_carry_only_conv: assert property (@(posedge CORE_CLK) disable iff (RST)
      RESULT_REPORT.valid && !RESULT_REPORT.conversion
      |=> !status_reg[float_status_pkg::CARRY_BIT])
      else $error("Carry flag set outside a conversion.");
endmodule : float_status_mode_register
`default_nettype wire

// File: fp_datapath_model.sv
`timescale 1ns/1ns
`default_nettype none
module fp_datapath_model (
   // Clock of the status block.
   input wire logic clk,
   // Answers from the status block.
   input wire logic operand_done,
   input wire logic operand_trap,
   input wire logic fp_trap,
   input wire float_status_pkg::store_control_type store_control,
   // Requests towards the status block.
   output float_status_pkg::operand_check_type operand_check,
   output float_status_pkg::result_report_type result_report
);
   // Both request buses start idle.
   initial begin
      operand_check = '0;
      result_report = '0;
   end

   // Presents one operand and waits for the verdict before the instruction runs.
   task automatic send_operand(input float_status_pkg::operand_check_type oc,
                               output logic [2:0] got);
      int n;
      @(posedge clk);
      operand_check <= oc;
      @(posedge clk);
      operand_check <= {1'b0, ~oc[17:0]};
      #1;
      for (n = 0; n < 4; n++) begin
         if (operand_done) break;
         @(posedge clk);
         #1;
      end
      got = {operand_done, operand_trap, fp_trap};
   endtask : send_operand

   // Reports one computed result; released lines carry a changed pattern, not the old one.
   task automatic send_result(input float_status_pkg::result_report_type r,
                              output float_status_pkg::store_control_type s, output logic t);
      @(posedge clk);
      result_report <= r;
      @(posedge clk);
      result_report <= {1'b0, ~r[81:0]};
      #1;
      s = store_control;
      t = fp_trap;
   endtask : send_result
endmodule : fp_datapath_model
`default_nettype wire

// File: float_status_mode_register_test.sv
`timescale 1ns/1ns
`default_nettype none
module float_status_mode_register_test;
   // One ordinary result case: mode loaded, report fields, expected answer.
   typedef struct {
      logic [15:0] mode;
      logic sign;
      logic [9:0] expo;
      logic [6:0] ev;
      logic [63:0] cval;
      logic fz;
      logic [7:0] sexp;
      logic trap;
      logic [15:0] status;
   } row_type;
   row_type rows [13];
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
   logic [31:0] aw_addr = '0, w_data = '0, ar_addr = '0, r_data;
   logic [3:0] w_strb = 4'h3;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, op_done, op_trap, fp_trap;
   logic dbl_m, long_m, chop_m, trap;
   logic [1:0] b_resp, r_resp, resp;
   logic [31:0] rd;
   float_status_pkg::operand_check_type oc;
   float_status_pkg::result_report_type rr;
   float_status_pkg::store_control_type sc;
   float_status_pkg::store_control_type st;
   int err_total = 0;
   int num_checks = 0;
   int i;

   // Clock at 10 MHz.
   always #50 core_clk = ~core_clk;

   // Block under test and the datapath beside it.
   float_status_mode_register dut (.CORE_CLK(core_clk), .RST(rst), .AWVALID(aw_valid),
      .AWREADY(aw_ready), .AWADDR(aw_addr), .WVALID(w_valid), .WREADY(w_ready), .WDATA(w_data),
      .WSTRB(w_strb), .BVALID(b_valid), .BREADY(b_ready), .BRESP(b_resp), .ARVALID(ar_valid),
      .ARREADY(ar_ready), .ARADDR(ar_addr), .RVALID(r_valid), .RREADY(r_ready), .RDATA(r_data),
      .RRESP(r_resp), .OPERAND_CHECK(oc), .RESULT_REPORT(rr), .OPERAND_DONE(op_done),
      .OPERAND_TRAP(op_trap), .STORE_CONTROL(sc), .FP_TRAP(fp_trap), .DOUBLE_MODE(dbl_m),
      .LONG_MODE(long_m), .CHOP_MODE(chop_m));
   fp_datapath_model datapath (.clk(core_clk), .operand_done(op_done), .operand_trap(op_trap),
      .fp_trap(fp_trap), .store_control(sc), .operand_check(oc), .result_report(rr));

   // Prints the verdict and stops the run.
   task automatic end_sim;
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // Compares one value and counts it.
   task automatic check(input logic [63:0] got, input logic [63:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check

   // One register write; waits for the response without assuming its delay.
   task automatic reg_write(input logic [31:0] addr, input logic [15:0] data,
                            output logic [1:0] rp);
      int n;
      rp = 2'h3;
      @(posedge core_clk);
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      aw_addr <= addr;
      w_data <= {16'h0000, data};
      b_ready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (aw_valid && aw_ready) aw_valid <= 1'b0;
         if (w_valid && w_ready) w_valid <= 1'b0;
         if (b_valid) begin
            rp = b_resp;
            b_ready <= 1'b0;
            break;
         end
      end
      if (n == 40) err_total++;
   endtask : reg_write

   // One register read.
   task automatic reg_read(input logic [31:0] addr, output logic [31:0] d,
                           output logic [1:0] rp);
      int n;
      d = '1;
      rp = 2'h3;
      @(posedge core_clk);
      ar_valid <= 1'b1;
      ar_addr <= addr;
      r_ready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (ar_valid && ar_ready) ar_valid <= 1'b0;
         if (r_valid) begin
            d = r_data;
            rp = r_resp;
            r_ready <= 1'b0;
            break;
         end
      end
      if (n == 40) err_total++;
   endtask : reg_read

   // Reads the status register and compares it.
   task automatic status_is(input logic [15:0] want);
      logic [31:0] d;
      logic [1:0] rp;
      reg_read(float_status_pkg::STATUS_OFFSET, d, rp);
      check(64'(d), 64'({16'h0000, want}));
   endtask : status_is

   // Loads a mode, presents one operand, checks the verdict {done, operand trap, trap}.
   task automatic op_case(input logic [15:0] mode, input logic [1:0] mc,
                          input logic [15:0] word, input logic [2:0] want);
      logic [2:0] got;
      reg_write(float_status_pkg::STATUS_OFFSET, mode, resp);
      datapath.send_operand({1'b1, mc, word}, got);
      check(64'(got), 64'(want));
      status_is(mode | {want[1], 15'h0000});
   endtask : op_case

   // Cuts a hang short.
   initial begin
      #3000000;
      err_total++;
      end_sim();
   end

   // Main sequence.
   initial begin
      rows = '{
         '{16'h0000, 1'b0, 10'h105, 7'h40, 64'h0, 1'b1, 8'h00, 1'b0, 16'h0006},
         '{16'h0200, 1'b1, 10'h105, 7'h40, 64'h0, 1'b0, 8'h05, 1'b1, 16'h820a},
         '{16'h0000, 1'b1, 10'h3fe, 7'h20, 64'h0, 1'b1, 8'h00, 1'b0, 16'h0004},
         '{16'h0400, 1'b0, 10'h300, 7'h20, 64'h0, 1'b0, 8'h00, 1'b1, 16'h8404},
         '{16'h0000, 1'b1, 10'h000, 7'h00, 64'h0, 1'b1, 8'h00, 1'b0, 16'h0004},
         '{16'h0100, 1'b0, 10'h090, 7'h04, 64'h8000, 1'b1, 8'h00, 1'b1, 16'h8100},
         '{16'h0140, 1'b0, 10'h090, 7'h07, 64'h8000, 1'b0, 8'h90, 1'b0, 16'h0141},
         '{16'h0040, 1'b1, 10'h0a0, 7'h04, 64'hffff_ffff_7fff_ffff, 1'b1, 8'h00, 1'b0, 16'h0040},
         '{16'h00e0, 1'b1, 10'h081, 7'h00, 64'h0, 1'b0, 8'h81, 1'b0, 16'h00e8},
         '{16'h4000, 1'b0, 10'h081, 7'h10, 64'h0, 1'b0, 8'h81, 1'b0, 16'hc000},
         '{16'h0000, 1'b0, 10'h081, 7'h08, 64'h0, 1'b0, 8'h81, 1'b1, 16'h8000},
         '{16'h4200, 1'b0, 10'h105, 7'h40, 64'h0, 1'b0, 8'h05, 1'b0, 16'hc202},
         '{16'h0100, 1'b1, 10'h090, 7'h04, 64'hffff_ffff_ffff_8000, 1'b0, 8'h90, 1'b0, 16'h0108}};
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      status_is(16'h0000);
      for (i = 0; i < 13; i++) begin
         reg_write(float_status_pkg::STATUS_OFFSET, rows[i].mode, resp);
         check(64'({dbl_m, long_m, chop_m}), 64'(rows[i].mode[7:5]));
         datapath.send_result({1'b1, rows[i].sign, rows[i].expo, rows[i].ev, rows[i].cval}, st, trap);
         check(64'({st.valid, st.force_zero, st.sign, st.exponent}), 64'({1'b1, rows[i].fz,
            rows[i].sign & !rows[i].fz, rows[i].sexp}));
         check(64'(trap), 64'(rows[i].trap));
         status_is(rows[i].status);
      end
      // The error flag survives later clean results until software loads the register.
      reg_write(float_status_pkg::STATUS_OFFSET, 16'h0000, resp);
      datapath.send_result({1'b1, 1'b0, 10'h081, 7'h08, 64'h0}, st, trap);
      datapath.send_result({1'b1, 1'b0, 10'h081, 7'h00, 64'h0}, st, trap);
      status_is(16'h8000);
      reg_write(float_status_pkg::STATUS_OFFSET, 16'h0000, resp);
      status_is(16'h0000);
      // Negative-zero operand checks.
      op_case(16'h0800, 2'h3, 16'h8000, 3'h7);
      op_case(16'h0800, 2'h2, 16'h8000, 3'h4);
      op_case(16'h0800, 2'h1, 16'h8000, 3'h4);
      op_case(16'h0000, 2'h3, 16'h8000, 3'h4);
      op_case(16'h0800, 2'h3, 16'h8080, 3'h4);
      op_case(16'h4800, 2'h3, 16'h807f, 3'h6);
      // Unmapped address is refused and leaves the status alone.
      reg_write(32'h0000_0010, 16'h0fff, resp);
      check(64'(resp), 64'(float_status_pkg::RESP_SLVERR));
      reg_read(32'h0000_0010, rd, resp);
      check(64'({resp, rd}), 64'({float_status_pkg::RESP_SLVERR, 32'h0000_0000}));
      status_is(16'hc800);
      // Byte strobes load only the selected half of the register.
      w_strb <= 4'h1;
      reg_write(float_status_pkg::STATUS_OFFSET, 16'h00ff, resp);
      status_is(16'hc8ef);
      w_strb <= 4'h2;
      reg_write(float_status_pkg::STATUS_OFFSET, 16'h0000, resp);
      status_is(16'h00ef);
      w_strb <= 4'h3;
      // Reserved bits stay clear; a mid-run reset clears everything.
      reg_write(float_status_pkg::STATUS_OFFSET, 16'hffff, resp);
      check(64'(resp), 64'(float_status_pkg::RESP_OKAY));
      status_is(16'hcfef);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      check(64'({dbl_m, long_m, chop_m}), 64'h0);
      status_is(16'h0000);
      end_sim();
   end
endmodule : float_status_mode_register_test
`default_nettype wire
